// [src/acc_ctrl.sv]
// What this block does
// - Standby run bit keeps comparator running
// - Stopped peripheral clock freezes flag, state
// - Pad driven only with pad enable set
// - Edge select: any, reserved, falling, rising
// - Low power bit drives reduced-current control
// - Hysteresis field passed to analog core
// - Control bit zero enables the comparator
// - Invert bit flips output for all consumers
// - Positive select routes positive pin zero-three
// - Negative select: pins zero-two, divider three
// - Reference level, reset 0xFF, sets divider
// - Enable register bit zero gates interrupt
// - State bit synchronised, three cycles late
// - Flag cleared by writing one only
// - Raw result high when positive exceeds negative
// - Flag set on edge, request while enabled
// - Power-down disables comparator and pad
module acc_ctrl #(
    parameter int unsigned ADDR_W = 6
) (
    // Clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // AXI4-Lite write address
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic [2:0]        awprot,
    // AXI4-Lite write data
    input  wire logic              wvalid,
    output logic                   wready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    // AXI4-Lite write response
    output logic                   bvalid,
    input  wire logic              bready,
    output logic [1:0]             bresp,
    // AXI4-Lite read address
    input  wire logic              arvalid,
    output logic                   arready,
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic [2:0]        arprot,
    // AXI4-Lite read data
    output logic                   rvalid,
    input  wire logic              rready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    // Power state from the system
    input  wire logic              sleep_standby,
    input  wire logic              sleep_power_down,
    input  wire logic              periph_clk_stopped,
    // Analog core result and controls
    input  wire logic              comparator_raw,
    output logic                   comparator_on,
    output logic                   low_power_select,
    output logic [1:0]             hysteresis_select,
    output logic [1:0]             positive_input_select,
    output logic [1:0]             negative_input_select,
    output logic [7:0]             divider_reference,
    // Output pin and event level
    output logic                   pad_out,
    output logic                   pad_out_oe,
    output logic                   comparator_out,
    // Interrupt
    output logic                   irq
);
    import acc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Register storage
    logic [7:0] ctl_ff;            // Control register
    logic [7:0] sel_ff;            // Input select register
    logic [7:0] ref_ff;            // Reference level
    logic [7:0] ien_ff;            // Interrupt enable
    logic       flag_ff;           // Sticky interrupt flag
    logic       state_ff;          // Synchronised, inverted state
    logic       sync_level;        // Synchroniser output

    // Bus slave state
    logic              awready_ff;
    logic              wready_ff;
    logic              bvalid_ff;
    logic              arready_ff;
    logic              rvalid_ff;
    logic [31:0]       rdata_ff;
    logic              aw_have_ff;
    logic              w_have_ff;
    logic [ADDR_W-1:0] waddr_ff;
    logic [7:0]        wbyte_ff;
    logic              wlane_ff;

    // Output flops
    logic       on_ff;
    logic       pad_ff;
    logic       pad_oe_ff;
    logic       out_ff;
    logic       irq_ff;

    // Combinational helpers
    logic       active;            // Comparator allowed to run
    logic       cur_level;         // Synchronised result after inversion
    logic       rise;              // Rising edge seen this cycle
    logic       fall;              // Falling edge seen this cycle
    logic       do_write;          // Both write halves present
    logic [7:0] wr_idx;            // Word index of write
    logic       flag_set;          // Edge hit
    logic       flag_clr;          // Software clear
    logic       nxt_flag;
    logic       nxt_state;

    ////////////////////////////////////////////////////////////////////////
    // Functions

    // Word index from a byte address; low two bits are the byte lane
    function automatic logic [7:0] word_index(input logic [ADDR_W-1:0] addr);
        logic [ADDR_W-1:0] shifted;
        shifted    = addr >> 2;
        word_index = 8'(shifted);
    endfunction : word_index

    // Edge qualification against the programmed edge code
    function automatic logic edge_hit(input logic [1:0] code,
                                      input logic       r,
                                      input logic       f);
        case (acc_edge_t'(code))
            EDGE_ANY:  edge_hit = r | f;
            EDGE_FALL: edge_hit = f;
            EDGE_RISE: edge_hit = r;
            default:   edge_hit = 1'b0;
        endcase
    endfunction : edge_hit

    ////////////////////////////////////////////////////////////////////////
    // Power gating of the comparator

    // Halted in standby unless told to run; always off in power-down
    always_comb begin
        active = ctl_ff[CTL_ENABLE_BIT];
        if (sleep_standby && !ctl_ff[CTL_STANDBY_RUN_BIT]) begin
            active = 1'b0;
        end
        if (sleep_power_down) begin
            active = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Result synchronisation and edge detection

    // The analog core already gives one when positive exceeds negative
    acc_sync #(
        .STAGES  (SYNC_STAGES)
    ) u_sync (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .async_in (comparator_raw),
        .sync_out (sync_level)
    );

    // Inversion after synchronising so status, edges and pad all agree
    assign cur_level = sync_level ^ sel_ff[SEL_INVERT_BIT];
    assign rise      = cur_level & ~state_ff;
    assign fall      = ~cur_level & state_ff;

    ////////////////////////////////////////////////////////////////////////
    // Bus write decode
    assign do_write = aw_have_ff && w_have_ff && !bvalid_ff;
    assign wr_idx   = word_index(waddr_ff);

    // Flag set and clear terms; a set in the clearing cycle wins
    assign flag_set = active && edge_hit(ctl_ff[CTL_EDGE_LSB +: 2], rise, fall);
    assign flag_clr = do_write && wlane_ff && wbyte_ff[STS_FLAG_BIT] &&
                      (wr_idx == 8'(IDX_COMPARATOR_STATUS) ||
                       wr_idx == 8'(IDX_IRQ_CLEAR));

    // Status next values; nothing moves while the clock is stopped
    always_comb begin
        nxt_flag  = flag_ff;
        nxt_state = state_ff;
        if (!periph_clk_stopped) begin
            nxt_flag  = flag_set | (flag_ff & ~flag_clr);
            nxt_state = cur_level;
        end
    end

    // Status flops
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flag_ff  <= 1'b0;
            state_ff <= 1'b0;
        end else begin
            flag_ff  <= nxt_flag;
            state_ff <= nxt_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Software-written registers

    // Only byte lane zero carries data; other lanes are ignored
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctl_ff <= RST_COMPARATOR_CONTROL;
            sel_ff <= RST_INPUT_SELECT;
            ref_ff <= RST_REFERENCE_LEVEL;
            ien_ff <= RST_IRQ_ENABLE;
        end else if (do_write && wlane_ff) begin
            case (wr_idx)
                8'(IDX_COMPARATOR_CONTROL): begin
                    ctl_ff <= wbyte_ff;
                end
                8'(IDX_INPUT_SELECT): begin
                    sel_ff <= wbyte_ff & SEL_WRITE_MASK;
                end
                8'(IDX_REFERENCE_LEVEL): begin
                    ref_ff <= wbyte_ff;
                end
                8'(IDX_IRQ_ENABLE): begin
                    ien_ff <= {7'h00, wbyte_ff[IEN_ENABLE_BIT]};
                end
                default: begin
                    // Reserved indices and status take no stored value
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write channels

    // Address and data taken in either order; both held until the response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_ff <= 1'b1;
            wready_ff  <= 1'b1;
            aw_have_ff <= 1'b0;
            w_have_ff  <= 1'b0;
            waddr_ff   <= '0;
            wbyte_ff   <= 8'h00;
            wlane_ff   <= 1'b0;
            bvalid_ff  <= 1'b0;
        end else begin
            if (awvalid && awready_ff) begin
                aw_have_ff <= 1'b1;
                awready_ff <= 1'b0;
                waddr_ff   <= awaddr;
            end
            if (wvalid && wready_ff) begin
                w_have_ff <= 1'b1;
                wready_ff <= 1'b0;
                wbyte_ff  <= wdata[7:0];
                wlane_ff  <= wstrb[0];
            end
            if (do_write) begin
                aw_have_ff <= 1'b0;
                w_have_ff  <= 1'b0;
                bvalid_ff  <= 1'b1;
            end
            // Ready returns only once the answer is taken
            if (bvalid_ff && bready) begin
                bvalid_ff  <= 1'b0;
                awready_ff <= 1'b1;
                wready_ff  <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read channels

    // Read data is captured at the address handshake, so it is a snapshot
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_ff <= 1'b1;
            rvalid_ff  <= 1'b0;
            rdata_ff   <= 32'h0000_0000;
        end else begin
            if (arvalid && arready_ff) begin
                arready_ff <= 1'b0;
                rvalid_ff  <= 1'b1;
                case (word_index(araddr))
                    8'(IDX_COMPARATOR_CONTROL): rdata_ff <= {24'h00_0000, ctl_ff};
                    8'(IDX_INPUT_SELECT):       rdata_ff <= {24'h00_0000, sel_ff};
                    8'(IDX_REFERENCE_LEVEL):    rdata_ff <= {24'h00_0000, ref_ff};
                    8'(IDX_IRQ_ENABLE):         rdata_ff <= {24'h00_0000, ien_ff};
                    8'(IDX_COMPARATOR_STATUS): begin
                        rdata_ff <= 32'h0000_0000;
                        rdata_ff[STS_STATE_BIT] <= state_ff;
                        rdata_ff[STS_FLAG_BIT]  <= flag_ff;
                    end
                    default: rdata_ff <= 32'h0000_0000;
                endcase
            end
            if (rvalid_ff && rready) begin
                rvalid_ff  <= 1'b0;
                arready_ff <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Analog core and pad outputs

    // Registered so every output comes straight from a flop
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            on_ff     <= 1'b0;
            pad_ff    <= 1'b0;
            pad_oe_ff <= 1'b0;
            out_ff    <= 1'b0;
        end else begin
            on_ff     <= active;
            out_ff    <= cur_level;
            pad_ff    <= cur_level;
            // Pad enable is also dropped in power-down, but not in standby
            pad_oe_ff <= ctl_ff[CTL_PAD_OE_BIT] && !sleep_power_down;
        end
    end

    // Control fields for the analog core
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            low_power_select      <= 1'b0;
            hysteresis_select     <= 2'h0;
            positive_input_select <= 2'h0;
            negative_input_select <= 2'h0;
            divider_reference     <= RST_REFERENCE_LEVEL;
        end else begin
            low_power_select      <= ctl_ff[CTL_LOW_POWER_BIT];
            hysteresis_select     <= ctl_ff[CTL_HYST_LSB +: 2];
            positive_input_select <= sel_ff[SEL_POS_LSB +: 2];
            negative_input_select <= sel_ff[SEL_NEG_LSB +: 2];
            divider_reference     <= ref_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt request

    // Level request while flag and enable are both set
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= flag_ff && ien_ff[IEN_ENABLE_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Port assignments
    assign awready        = awready_ff;
    assign wready         = wready_ff;
    assign bvalid         = bvalid_ff;
    assign bresp          = RESP_OKAY;
    assign arready        = arready_ff;
    assign rvalid         = rvalid_ff;
    assign rdata          = rdata_ff;
    assign rresp          = RESP_OKAY;
    assign comparator_on  = on_ff;
    assign pad_out        = pad_ff;
    assign pad_out_oe     = pad_oe_ff;
    assign comparator_out = out_ff;
    assign irq            = irq_ff;

endmodule : acc_ctrl

// [src/acc_pkg.sv]
package acc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register indices; byte address is four times the index
    localparam int unsigned IDX_COMPARATOR_CONTROL = 0;    // Control register
    localparam int unsigned IDX_INPUT_SELECT       = 2;    // Input multiplexer
    localparam int unsigned IDX_REFERENCE_LEVEL    = 4;    // Divider level
    localparam int unsigned IDX_IRQ_ENABLE         = 6;    // Interrupt enable
    localparam int unsigned IDX_COMPARATOR_STATUS  = 7;    // Flag and state
    localparam int unsigned IDX_IRQ_CLEAR          = 8;    // Write-only clear

    ////////////////////////////////////////////////////////////////////////
    // Control register fields
    localparam int unsigned CTL_ENABLE_BIT      = 0;       // Comparator on
    localparam int unsigned CTL_HYST_LSB        = 1;       // Hysteresis [2:1]
    localparam int unsigned CTL_LOW_POWER_BIT   = 3;       // Reduced current
    localparam int unsigned CTL_EDGE_LSB        = 4;       // Edge select [5:4]
    localparam int unsigned CTL_PAD_OE_BIT      = 6;       // Pad output enable
    localparam int unsigned CTL_STANDBY_RUN_BIT = 7;       // Run in standby

    // Input select fields
    localparam int unsigned SEL_NEG_LSB         = 0;       // Negative [1:0]
    localparam int unsigned SEL_POS_LSB         = 3;       // Positive [4:3]
    localparam int unsigned SEL_INVERT_BIT      = 7;       // Output inversion
    localparam logic [7:0]  SEL_WRITE_MASK      = 8'h9b;   // Implemented bits

    // Status and enable fields
    localparam int unsigned STS_FLAG_BIT        = 0;       // Interrupt flag
    localparam int unsigned STS_STATE_BIT       = 4;       // Synchronised state
    localparam int unsigned IEN_ENABLE_BIT      = 0;       // Interrupt enable

    ////////////////////////////////////////////////////////////////////////
    // Values after reset
    localparam logic [7:0]  RST_COMPARATOR_CONTROL = 8'h00;
    localparam logic [7:0]  RST_INPUT_SELECT       = 8'h00;
    localparam logic [7:0]  RST_REFERENCE_LEVEL    = 8'hff;
    localparam logic [7:0]  RST_IRQ_ENABLE         = 8'h00;

    // Synchroniser depth ahead of the status state flip-flop
    localparam int unsigned SYNC_STAGES = 2;

    // Negative select code that routes the internal divider
    localparam logic [1:0]  NEG_DIVIDER_REF = 2'h3;

    // Bus answer codes
    localparam logic [1:0]  RESP_OKAY = 2'h0;

    ////////////////////////////////////////////////////////////////////////
    // Interrupt edge selection codes
    typedef enum logic [1:0] {
        EDGE_ANY      = 2'b00,
        EDGE_RESERVED = 2'b01,
        EDGE_FALL     = 2'b10,
        EDGE_RISE     = 2'b11
    } acc_edge_t;

endpackage : acc_pkg

// [src/acc_sync.sv]
// Two-stage synchroniser for the comparator result
module acc_sync #(
    parameter int unsigned STAGES = acc_pkg::SYNC_STAGES
) (
    // Clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // Asynchronous level in, synchronised level out
    input  wire logic async_in,
    output logic      sync_out
);
    import acc_pkg::*;

    // Shift chain; only the last stage is looked at outside
    logic [STAGES-1:0] chain_ff;

    // Each stage feeds the next and nothing else
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            chain_ff <= '0;
        end else begin
            chain_ff <= {chain_ff[STAGES-2:0], async_in};
        end
    end

    assign sync_out = chain_ff[STAGES-1];

endmodule : acc_sync

// [sim/acc_ctrl_props.sv]
module acc_ctrl_props (
    // Clock and reset
    input wire logic       aclk,
    input wire logic       aresetn,
    // Bus answer, system power state and raw result
    input wire logic       bvalid,
    input wire logic       sleep_standby,
    input wire logic       sleep_power_down,
    input wire logic       comparator_raw,
    // Analog core controls
    input wire logic       comparator_on,
    input wire logic       low_power_select,
    input wire logic [1:0] hysteresis_select,
    input wire logic [1:0] positive_input_select,
    input wire logic [1:0] negative_input_select,
    input wire logic [7:0] divider_reference,
    // Pad, event level and interrupt
    input wire logic       pad_out,
    input wire logic       pad_out_oe,
    input wire logic       comparator_out,
    input wire logic       irq
);
    timeunit 1ns;
    timeprecision 1ns;
    // One clock domain, so one clocking and one disable for all
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    ////////////////////////////////////////////////////////////////////////
    property p_out_pair;
        pad_out == comparator_out;
    endproperty
    a_out_pair: assert property (p_out_pair) else $error("pad and event level differ");
    property p_oe_pd;
        sleep_power_down |=> !pad_out_oe;
    endproperty
    a_oe_pd: assert property (p_oe_pd) else $error("pad enabled in power-down");
    property p_on_pd;
        sleep_power_down |=> !comparator_on;
    endproperty
    a_on_pd: assert property (p_on_pd) else $error("comparator on in power-down");
    // Enable may only move after a write or a change of sleep state
    property p_on_cause;
        $changed(comparator_on) |-> bvalid || $past(bvalid) || $past(bvalid, 2)
            || $past(sleep_standby) != $past(sleep_standby, 2)
            || $past(sleep_power_down) != $past(sleep_power_down, 2);
    endproperty
    a_on_cause: assert property (p_on_cause) else $error("enable moved uncaused");
    property p_oe_cause;
        $changed(pad_out_oe) |-> bvalid || $past(bvalid)
            || $past(sleep_power_down) != $past(sleep_power_down, 2);
    endproperty
    a_oe_cause: assert property (p_oe_cause) else $error("pad enable moved uncaused");
    property p_cfg_cause;
        $changed({low_power_select, hysteresis_select, positive_input_select,
                  negative_input_select, divider_reference}) |-> bvalid || $past(bvalid);
    endproperty
    a_cfg_cause: assert property (p_cfg_cause) else $error("controls moved uncaused");
    // Raw change lands on the pad three edges later, or a write flips it
    property p_pad_cause;
        $changed(pad_out) |-> $past(comparator_raw, 3) != $past(comparator_raw, 4)
            || bvalid || $past(bvalid) || $past(bvalid, 2);
    endproperty
    a_pad_cause: assert property (p_pad_cause) else $error("pad moved uncaused");
    property p_irq_fall;
        $fell(irq) |-> $past(bvalid);
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("request dropped without write");
    property p_irq_rise;
        $rose(irq) |-> $past(bvalid) || $past(bvalid, 2)
            || $past(comparator_out) != $past(comparator_out, 2);
    endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("request raised uncaused");
endmodule : acc_ctrl_props

bind acc_ctrl acc_ctrl_props u_props (
    .aclk, .aresetn, .bvalid, .sleep_standby, .sleep_power_down, .comparator_raw,
    .comparator_on, .low_power_select, .hysteresis_select, .positive_input_select,
    .negative_input_select, .divider_reference, .pad_out, .pad_out_oe,
    .comparator_out, .irq
);

// [sim/tb.sv]
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import acc_pkg::*;
    // Stimulus, all given a value at time zero
    logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, sby = 1'b0, pdn = 1'b0, stp = 1'b0, raw = 1'b0;
    logic [5:0]  awaddr = '0, araddr = '0;
    logic [31:0] wdata  = '0;
    // Observed outputs
    logic awready, wready, bvalid, arready, rvalid, on, lp, oe, pad, co, irq;
    logic [1:0]  bresp, rresp, hys, psel, nsel;
    logic [7:0]  dref;
    logic [31:0] rdata;
    int fails = 0, comparisons = 0;
    logic inv = 1'b0; // Expected inversion setting
    int unsigned ri [7] = '{IDX_COMPARATOR_CONTROL, IDX_INPUT_SELECT, IDX_REFERENCE_LEVEL,
                            IDX_IRQ_ENABLE, IDX_COMPARATOR_STATUS, IDX_IRQ_CLEAR, 15};
    logic [7:0]  re [7] = '{8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00};

    acc_ctrl uut (
        .aclk, .aresetn, .awvalid, .awready, .awaddr, .awprot(3'h0), .wvalid, .wready,
        .wdata, .wstrb(4'hf), .bvalid, .bready, .bresp, .arvalid, .arready, .araddr,
        .arprot(3'h0), .rvalid, .rready, .rdata, .rresp, .sleep_standby(sby),
        .sleep_power_down(pdn), .periph_clk_stopped(stp), .comparator_raw(raw),
        .comparator_on(on), .low_power_select(lp), .hysteresis_select(hys),
        .positive_input_select(psel), .negative_input_select(nsel), .divider_reference(dref),
        .pad_out(pad), .pad_out_oe(oe), .comparator_out(co), .irq
    );

    // 20 MHz clock
    initial begin
        forever #25 aclk = ~aclk;
    end

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [5:0] ba(input int unsigned i);
        return 6'(4 * i); // Byte address is four times the index
    endfunction : ba
    task automatic final_report;
        $display("checks %0d mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : final_report
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // Bus write: address and data offered together, held until taken
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        int n = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h00_0000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 50);
        bready <= 1'b0;
        chk("write answer", 32'(RESP_OKAY), 32'(bresp));
        if (n >= 50) begin
            fails++;
            final_report();
        end
        @(posedge aclk);
    endtask : wr
    // Bus read and compare of the low byte, upper bytes must be zero
    task automatic rdc(input logic [5:0] a, input logic [7:0] e);
        int n = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 50);
        rready <= 1'b0;
        if (n >= 50) begin
            fails++;
            final_report();
        end
        chk("read data", {24'h00_0000, e}, rdata);
        chk("read answer", 32'(RESP_OKAY), 32'(rresp));
    endtask : rdc
    // Move the raw result; the pad holds for three edges, then follows
    task automatic tog(input logic v);
        @(posedge aclk);
        raw <= v;
        repeat (3) @(posedge aclk);
        chk("pad early", 32'(!v ^ inv), 32'(pad));
        @(posedge aclk);
        chk("pad", 32'(v ^ inv), 32'(pad));
    endtask : tog

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            rdc(ba(ri[i]), re[i]);
        end
        chk("divider", 32'h0000_00ff, 32'(dref));
        wr(ba(IDX_REFERENCE_LEVEL), 8'h5a);
        chk("divider", 32'h0000_005a, 32'(dref));
        $display("test reset and reference done");
        // Every hysteresis, positive and negative code
        for (int i = 0; i < 4; i++) begin
            wr(ba(IDX_COMPARATOR_CONTROL), 8'(8'h01 | (i << 1) | ((i & 1) << 3)));
            wr(ba(IDX_INPUT_SELECT), 8'((i << 3) | (3 - i)));
            chk("hysteresis", 32'(i), 32'(hys));
            chk("low power", 32'(i & 1), 32'(lp));
            chk("positive", 32'(i), 32'(psel));
            chk("negative", 32'(3 - i), 32'(nsel));
            chk("enable", 32'h0000_0001, 32'(on));
            chk("pad enable", 32'h0000_0000, 32'(oe));
        end
        $display("test controls done");
        // Each edge code on a rise and a fall, clearing by both places
        wr(ba(IDX_IRQ_ENABLE), 8'h01);
        for (int m = 0; m < 4; m++) begin
            wr(ba(IDX_COMPARATOR_CONTROL), 8'(8'h41 | (m << 4)));
            chk("pad enable", 32'h0000_0001, 32'(oe));
            tog(1'b1);
            rdc(ba(IDX_COMPARATOR_STATUS), 8'(8'h10 | (m == 0 || m == 3)));
            chk("irq", 32'(m == 0 || m == 3), 32'(irq));
            wr(ba(IDX_IRQ_CLEAR), 8'h01);
            tog(1'b0);
            rdc(ba(IDX_COMPARATOR_STATUS), 8'(m == 0 || m == 2));
            wr(ba(IDX_COMPARATOR_STATUS), 8'h01);
        end
        $display("test edge codes done");
        // Zero writes leave the flag; mask and unmask the request
        tog(1'b1);
        wr(ba(IDX_COMPARATOR_STATUS), 8'h00);
        rdc(ba(IDX_COMPARATOR_STATUS), 8'h11);
        wr(ba(IDX_IRQ_ENABLE), 8'h00);
        chk("irq masked", 32'h0000_0000, 32'(irq));
        wr(ba(IDX_IRQ_ENABLE), 8'h01);
        chk("irq", 32'h0000_0001, 32'(irq));
        wr(ba(IDX_COMPARATOR_STATUS), 8'h01);
        rdc(ba(IDX_COMPARATOR_STATUS), 8'h10);
        chk("irq cleared", 32'h0000_0000, 32'(irq));
        // Inversion: a falling raw result is a rise; unused select bits read zero
        wr(ba(IDX_INPUT_SELECT), 8'hff);
        inv = 1'b1;
        rdc(ba(IDX_INPUT_SELECT), 8'h9b);
        tog(1'b0);
        rdc(ba(IDX_COMPARATOR_STATUS), 8'h11);
        wr(ba(IDX_COMPARATOR_STATUS), 8'h01);
        $display("test clear and invert done");
        // Standby with and without run, then power-down
        wr(ba(IDX_COMPARATOR_CONTROL), 8'hc1);
        sby <= 1'b1;
        repeat (3) @(posedge aclk);
        chk("standby run", 32'h0000_0001, 32'(on));
        wr(ba(IDX_COMPARATOR_CONTROL), 8'h41);
        chk("standby halt", 32'h0000_0000, 32'(on));
        pdn <= 1'b1;
        repeat (3) @(posedge aclk);
        chk("power-down pad", 32'h0000_0000, 32'(oe));
        sby <= 1'b0;
        pdn <= 1'b0;
        $display("test sleep done");
        // A pulse while the clock is stopped must leave no trace
        wr(ba(IDX_COMPARATOR_CONTROL), 8'h01);
        stp <= 1'b1;
        tog(1'b1);
        tog(1'b0);
        stp <= 1'b0;
        rdc(ba(IDX_COMPARATOR_STATUS), 8'h10);
        chk("irq frozen", 32'h0000_0000, 32'(irq));
        $display("test stopped clock done");
        final_report();
    end
endmodule : tb
